// file: src/obd_pkg.sv
// Constants shared by the option board decode and isolation logic
package obd_pkg;

    // ------------------------------------------------------------------
    // Address window of the bus controller chip
    // ------------------------------------------------------------------
    localparam logic [15:0] OBD_ADDR_LO    = 16'h0028;  // First address, inclusive
    localparam logic [15:0] OBD_ADDR_HI    = 16'h002F;  // Last address, inclusive
    localparam int          OBD_DEC_MSB    = 15;        // Top compared address bit
    localparam int          OBD_DEC_LSB    = 3;         // Lowest compared address bit
    localparam int          OBD_DEC_W      = OBD_DEC_MSB - OBD_DEC_LSB + 1;
    localparam logic [12:0] OBD_DEC_MATCH  = OBD_ADDR_LO[15:3];

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int          OBD_ADDR_W     = 16;        // Processor address bus
    localparam int          OBD_DATA_W     = 8;         // Processor data bus
    localparam int          OBD_REG_SEL_W  = 3;         // Controller register select
    localparam int          OBD_SYNC_W     = 39;        // All pin inputs, synchronised

    // ------------------------------------------------------------------
    // Reset values of the outputs
    // ------------------------------------------------------------------
    localparam logic        OBD_RST_CS_N   = 1'b1;      // Chip select idle high
    localparam logic        OBD_RST_OE     = 1'b0;      // Every buffer tri-stated
    localparam logic        OBD_RST_CTRL_N = 1'b0;      // Controller held in reset
    localparam logic        OBD_PRESENT    = 1'b0;      // Sense line tied to ground
    localparam logic [7:0]  OBD_RST_DATA   = 8'h00;     // Data outputs idle value

    // Decode of the thirteen upper address bits
    function automatic logic obd_addr_hit(input logic [15:0] addr);
        obd_addr_hit = (addr[OBD_DEC_MSB:OBD_DEC_LSB] == OBD_DEC_MATCH);
    endfunction : obd_addr_hit

endpackage : obd_pkg

// file: src/obd_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module obd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // --------------------------------------------------------------
    // One flip-flop pair per bit; the first stage feeds only the second
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    stage1[gi]   <= 1'b0;
                    sync_out[gi] <= 1'b0;
                end else begin
                    stage1[gi]   <= async_in[gi];
                    sync_out[gi] <= stage1[gi];
                end
            end
        end
    endgenerate

endmodule : obd_sync

// file: src/obd_top.sv
// Option board address decode, power isolation and data steering
`timescale 1ns/1ps
module obd_top (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    // Processor side pins
    input  wire logic [obd_pkg::OBD_ADDR_W-1:0] cpu_addr,
    input  wire logic                          cpu_read_not_write,
    input  wire logic                          cpu_write_strobe_n,
    input  wire logic                          cpu_read_strobe,
    input  wire logic                          cpu_phase_clk,
    input  wire logic                          system_reset,
    input  wire logic                          option_power_switch_n,
    input  wire logic [obd_pkg::OBD_DATA_W-1:0] cpu_data_in,
    output logic      [obd_pkg::OBD_DATA_W-1:0] cpu_data_out,
    output logic                               cpu_data_oe,
    output logic                               option_interrupt_request_n,
    output logic                               option_interrupt_request_oe,
    output logic                               option_present_sense,
    // Controller side through the isolating buffer
    output logic [obd_pkg::OBD_REG_SEL_W-1:0]  ctrl_reg_sel,
    output logic                               ctrl_write_strobe_n,
    output logic                               ctrl_read_strobe,
    output logic                               ctrl_phase_clk,
    output logic                               ctrl_chip_select_n,
    output logic                               ctrl_iso_oe,
    output logic                               ctrl_reset_n,
    input  wire logic                          ctrl_interrupt_n,
    // Controller side data
    input  wire logic [obd_pkg::OBD_DATA_W-1:0] ctrl_data_in,
    output logic      [obd_pkg::OBD_DATA_W-1:0] ctrl_data_out,
    output logic                               ctrl_data_oe
);
    import obd_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [OBD_SYNC_W-1:0] pins_async;
    logic [OBD_SYNC_W-1:0] pins_sync;

    // Every pin comes from another domain, so all pass two flip-flops;
    // active-low pins go in inverted so cleared stages read as idle
    assign pins_async = {cpu_addr, cpu_read_not_write, !cpu_write_strobe_n,
                         cpu_read_strobe, cpu_phase_clk, system_reset,
                         !option_power_switch_n, !ctrl_interrupt_n,
                         cpu_data_in, ctrl_data_in};

    obd_sync #(
        .WIDTH    (OBD_SYNC_W)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // ------------------------------------------------------------------
    // Synchronised pin fields
    // ------------------------------------------------------------------
    logic [OBD_ADDR_W-1:0] s_addr;
    logic                  s_rnw;
    logic                  s_wr;
    logic                  s_rd;
    logic                  s_phase;
    logic                  s_sysrst;
    logic                  s_sw_on;
    logic                  s_irq;
    logic [OBD_DATA_W-1:0] s_cpu_data;
    logic [OBD_DATA_W-1:0] s_ctrl_data;

    // Unpack in the same order as packed above
    assign {s_addr, s_rnw, s_wr, s_rd, s_phase, s_sysrst,
            s_sw_on, s_irq, s_cpu_data, s_ctrl_data} = pins_sync;

    // ------------------------------------------------------------------
    // Address decode and power gating
    // ------------------------------------------------------------------
    logic power_on;
    logic addr_hit;
    logic board_cycle;
    logic next_cs_n;
    logic hold_reset;
    logic cs_end;

    // Switch synchronised inverted; a cleared stage reads as power off
    assign power_on    = s_sw_on;
    assign addr_hit    = obd_addr_hit(s_addr);
    // Without option power the decoder is dead; no select can form
    assign board_cycle = power_on && addr_hit;
    assign next_cs_n   = !board_cycle;
    // Reset dominates whenever either source is active
    assign hold_reset  = s_sysrst || !power_on;
    // Rising end of the select, seen against the registered output
    assign cs_end      = !ctrl_chip_select_n && next_cs_n;

    // ------------------------------------------------------------------
    // Chip select and isolating buffer
    // ------------------------------------------------------------------
    // The buffer enable follows the switch, so an unpowered controller
    // is never driven and never sources current through its inputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_chip_select_n <= OBD_RST_CS_N;
            ctrl_iso_oe        <= OBD_RST_OE;
            ctrl_reg_sel       <= '0;
            ctrl_write_strobe_n <= 1'b1;
            ctrl_read_strobe   <= 1'b0;
            ctrl_phase_clk     <= 1'b0;
        end else begin
            ctrl_chip_select_n <= next_cs_n;
            ctrl_iso_oe        <= power_on;
            ctrl_reg_sel       <= s_addr[OBD_REG_SEL_W-1:0];
            ctrl_write_strobe_n <= !s_wr;
            ctrl_read_strobe   <= s_rd;
            ctrl_phase_clk     <= s_phase;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt path toward the processor
    // ------------------------------------------------------------------
    // Cut off on battery; the external pull-up then keeps the line high
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            option_interrupt_request_n  <= 1'b1;
            option_interrupt_request_oe <= OBD_RST_OE;
        end else begin
            option_interrupt_request_n  <= !s_irq;
            option_interrupt_request_oe <= power_on;
        end
    end

    // ------------------------------------------------------------------
    // Presence sense
    // ------------------------------------------------------------------
    // Board ties the line to ground; kept as a flop for a clean output
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            option_present_sense <= OBD_PRESENT;
        end else begin
            option_present_sense <= OBD_PRESENT;
        end
    end

    // ------------------------------------------------------------------
    // Controller reset flip-flop
    // ------------------------------------------------------------------
    // Release needs a dummy access after power up; the processor is
    // trusted to wait for the supply to settle before making it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_reset_n <= OBD_RST_CTRL_N;
        end else if (hold_reset) begin
            ctrl_reset_n <= OBD_RST_CTRL_N;
        end else if (cs_end) begin
            ctrl_reset_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Data transceiver steering
    // ------------------------------------------------------------------
    // Both sides float outside option cycles to avoid bus contention
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cpu_data_oe   <= OBD_RST_OE;
            ctrl_data_oe  <= OBD_RST_OE;
            cpu_data_out  <= OBD_RST_DATA;
            ctrl_data_out <= OBD_RST_DATA;
        end else begin
            cpu_data_oe   <= board_cycle && s_rnw;
            ctrl_data_oe  <= board_cycle && !s_rnw;
            cpu_data_out  <= s_ctrl_data;
            ctrl_data_out <= s_cpu_data;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_release_cond;
        !hold_reset && cs_end;
    endsequence

    property p_cs_range;
        @(posedge core_clk) disable iff (!nrst)
        !ctrl_chip_select_n |-> $past(power_on) &&
            ($past(s_addr) >= OBD_ADDR_LO) && ($past(s_addr) <= OBD_ADDR_HI);
    endproperty
    a_cs_range: assert property (p_cs_range) else $error("select outside window");

    property p_cs_bits;
        @(posedge core_clk) disable iff (!nrst)
        (power_on && s_addr[15:3] == 13'h0005) |=> !ctrl_chip_select_n;
    endproperty
    a_cs_bits: assert property (p_cs_bits) else $error("select missed on match");

    property p_off_quiet;
        @(posedge core_clk) disable iff (!nrst)
        !power_on |=> ctrl_chip_select_n && !cpu_data_oe && !ctrl_data_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("activity while off");

    property p_iso_off;
        @(posedge core_clk) disable iff (!nrst)
        !power_on |=> !ctrl_iso_oe && !option_interrupt_request_oe;
    endproperty
    a_iso_off: assert property (p_iso_off) else $error("buffer not isolated");

    property p_present;
        @(posedge core_clk) disable iff (!nrst)
        1'b1 |=> !option_present_sense;
    endproperty
    a_present: assert property (p_present) else $error("presence not low");

    property p_xcvr_cycle;
        @(posedge core_clk) disable iff (!nrst)
        (cpu_data_oe || ctrl_data_oe) |-> !ctrl_chip_select_n && ctrl_iso_oe;
    endproperty
    a_xcvr_cycle: assert property (p_xcvr_cycle) else $error("transceiver stray");

    property p_read_dir;
        @(posedge core_clk) disable iff (!nrst)
        cpu_data_oe |-> $past(s_rnw) && !ctrl_data_oe &&
            (cpu_data_out == $past(s_ctrl_data));
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("read direction wrong");

    property p_write_dir;
        @(posedge core_clk) disable iff (!nrst)
        ctrl_data_oe |-> !$past(s_rnw) && !cpu_data_oe &&
            (ctrl_data_out == $past(s_cpu_data));
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("write direction wrong");

    property p_reset_hold;
        @(posedge core_clk) disable iff (!nrst)
        hold_reset |=> !ctrl_reset_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset not held");

    property p_reset_release;
        @(posedge core_clk) disable iff (!nrst)
        s_release_cond |=> ctrl_reset_n;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset not released");

    property p_release_cause;
        @(posedge core_clk) disable iff (!nrst)
        $rose(ctrl_reset_n) |-> !$past(ctrl_chip_select_n) && ctrl_chip_select_n;
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("release without select end");

endmodule : obd_top

// file: tb/obd_cpu_model.sv
// Processor memory bus model that drives the option board pins
`timescale 1ns/1ps
module obd_cpu_model (
    // Clock
    input  wire logic                      core_clk,
    // Board status seen by the processor
    input  wire logic                      ac_line_on_n,
    input  wire logic                      option_present_sense,
    // Memory bus pins
    output logic [obd_pkg::OBD_ADDR_W-1:0] cpu_addr,
    output logic                           cpu_read_not_write,
    output logic                           cpu_write_strobe_n,
    output logic                           cpu_read_strobe,
    output logic                           cpu_phase_clk,
    output logic                           system_reset,
    output logic                           option_power_switch_n,
    output logic [obd_pkg::OBD_DATA_W-1:0] cpu_data_in
);
    import obd_pkg::*;

    // Shortened power settle; the real wait is far longer than the bench can afford
    localparam int POWER_WAIT = 20;
    localparam int SETTLE     = 5;  // Two sync stages, one output stage, margin

    // Meter power up: option power off, system reset high
    initial begin
        cpu_addr              = 16'h0000;
        cpu_read_not_write    = 1'b1;
        cpu_write_strobe_n    = 1'b1;
        cpu_read_strobe       = 1'b0;
        cpu_phase_clk         = 1'b0;
        system_reset          = 1'b1;
        option_power_switch_n = 1'b1;
        cpu_data_in           = 8'h00;
    end

    // Option power follows mains, and only for a fitted board
    task automatic set_power();
        @(posedge core_clk);
        option_power_switch_n <= !(ac_line_on_n === 1'b0 && option_present_sense === 1'b0);
        repeat (POWER_WAIT) @(posedge core_clk);
        #1;
    endtask : set_power

    // System reset level
    task automatic set_system_reset(input logic level);
        @(posedge core_clk);
        system_reset <= level;
        repeat (SETTLE) @(posedge core_clk);
        #1;
    endtask : set_system_reset

    // Open a memory cycle and hold it; a read drives the data lines with their inverted value
    task automatic start_cycle(input logic [15:0] addr, input logic rnw, input logic [7:0] wdata);
        @(posedge core_clk);
        cpu_addr           <= addr;
        cpu_read_not_write <= rnw;
        cpu_read_strobe    <= rnw;
        cpu_write_strobe_n <= rnw;
        cpu_phase_clk      <= 1'b1;
        cpu_data_in        <= rnw ? ~cpu_data_in : wdata;
        repeat (SETTLE) @(posedge core_clk);
        #1;
    endtask : start_cycle

    // Close the cycle: address parked outside the window, data lines inverted
    task automatic end_cycle();
        @(posedge core_clk);
        cpu_addr           <= 16'h0000;
        cpu_read_strobe    <= 1'b0;
        cpu_write_strobe_n <= 1'b1;
        cpu_phase_clk      <= 1'b0;
        cpu_data_in        <= ~cpu_data_in;
        repeat (SETTLE) @(posedge core_clk);
        #1;
    endtask : end_cycle

endmodule : obd_cpu_model

// file: tb/tb_obd_top.sv
// Self-checking testbench for the option board decode and isolation logic
`timescale 1ns/1ps
module tb_obd_top;
    import obd_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk;
    logic        nrst;
    logic        ac_line_on_n;
    logic        ctrl_interrupt_n;
    logic [7:0]  ctrl_data_in;
    wire  [15:0] cpu_addr;
    wire  [7:0]  cpu_data_in, cpu_data_out, ctrl_data_out;
    wire  [2:0]  ctrl_reg_sel;
    wire         cpu_read_not_write, cpu_write_strobe_n, cpu_read_strobe, cpu_phase_clk;
    wire         system_reset, option_power_switch_n, cpu_data_oe, option_present_sense;
    wire         option_interrupt_request_n, option_interrupt_request_oe;
    wire         ctrl_write_strobe_n, ctrl_read_strobe, ctrl_phase_clk, ctrl_chip_select_n;
    wire         ctrl_iso_oe, ctrl_reset_n, ctrl_data_oe;
    int          miscompares;
    int          total_checks;

    // Processor model and the block
    obd_cpu_model obd_cpu_model_i (.core_clk, .ac_line_on_n, .option_present_sense, .cpu_addr,
        .cpu_read_not_write, .cpu_write_strobe_n, .cpu_read_strobe, .cpu_phase_clk,
        .system_reset, .option_power_switch_n, .cpu_data_in);
    obd_top obd_top_i (.core_clk, .nrst, .cpu_addr, .cpu_read_not_write, .cpu_write_strobe_n,
        .cpu_read_strobe, .cpu_phase_clk, .system_reset, .option_power_switch_n, .cpu_data_in,
        .cpu_data_out, .cpu_data_oe, .option_interrupt_request_n, .option_interrupt_request_oe,
        .option_present_sense, .ctrl_reg_sel, .ctrl_write_strobe_n, .ctrl_read_strobe,
        .ctrl_phase_clk, .ctrl_chip_select_n, .ctrl_iso_oe, .ctrl_reset_n, .ctrl_interrupt_n,
        .ctrl_data_in, .ctrl_data_out, .ctrl_data_oe);

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string what);
        total_checks++;
        if (seen !== expd) begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, expd);
        end
    endtask : check

    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, miscompares);
    endtask : end_test

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Window edges, an upper-bit alias, reads and writes alternating
    task automatic run_decode();
        logic [15:0] addr_tab [7];
        logic        hit;
        logic        rnw;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        addr_tab = '{16'h0027, 16'h0028, 16'h002B, 16'h002E, 16'h002F, 16'h0030, 16'h8028};
        for (int i = 0; i < 7; i++) begin
            rnw   = i[0];
            wdata = 8'hC3 ^ 8'(i);
            rdata = 8'h3C + 8'(i);
            hit   = addr_tab[i] >= OBD_ADDR_LO && addr_tab[i] <= OBD_ADDR_HI;
            @(posedge core_clk) ctrl_data_in <= rdata;
            obd_cpu_model_i.start_cycle(addr_tab[i], rnw, wdata);
            check(ctrl_chip_select_n, !hit, "select");
            check(ctrl_reg_sel, addr_tab[i][2:0], "reg select");
            check({ctrl_read_strobe, ctrl_write_strobe_n, ctrl_phase_clk}, {rnw, rnw, 1'b1}, "strobes");
            check(cpu_data_oe, hit & rnw, "cpu side oe");
            check(ctrl_data_oe, hit & !rnw, "ctrl side oe");
            if (hit && rnw) check(cpu_data_out, rdata, "read data");
            if (hit && !rnw) check(ctrl_data_out, wdata, "write data");
            @(posedge core_clk) ctrl_data_in <= ~rdata;
            obd_cpu_model_i.end_cycle();
            check({cpu_data_oe, ctrl_data_oe, ctrl_chip_select_n}, 3'b001, "idle");
        end
        end_test("decode");
    endtask : run_decode

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst             = 1'b0;
        ac_line_on_n     = 1'b1;
        ctrl_interrupt_n = 1'b1;
        ctrl_data_in     = 8'h00;
        miscompares      = 0;
        total_checks     = 0;
        // Two edges clear every flop, synchroniser stages included
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check(ctrl_chip_select_n, OBD_RST_CS_N, "select idle");
        check({ctrl_iso_oe, cpu_data_oe, ctrl_data_oe, option_interrupt_request_oe}, 4'h0, "oe");
        check(ctrl_reset_n, OBD_RST_CTRL_N, "ctrl reset");
        check(option_present_sense, OBD_PRESENT, "present");
        end_test("reset");
        // Battery: a window access must not reach the controller
        obd_cpu_model_i.start_cycle(16'h002A, 1'b1, 8'h00);
        check(ctrl_chip_select_n, 1'b1, "select on battery");
        check({ctrl_iso_oe, option_interrupt_request_oe, cpu_data_oe}, 3'h0, "isolated");
        obd_cpu_model_i.end_cycle();
        end_test("battery");
        // Mains power; a select under system reset releases nothing
        @(posedge core_clk) ac_line_on_n <= 1'b0;
        obd_cpu_model_i.set_power();
        check({ctrl_iso_oe, option_interrupt_request_oe}, 2'b11, "buffer on");
        obd_cpu_model_i.start_cycle(16'h0028, 1'b1, 8'h00);
        obd_cpu_model_i.end_cycle();
        check(ctrl_reset_n, 1'b0, "held by system reset");
        obd_cpu_model_i.set_system_reset(1'b0);
        obd_cpu_model_i.start_cycle(16'h0028, 1'b1, 8'h00);
        check(ctrl_reset_n, 1'b0, "held during select");
        obd_cpu_model_i.end_cycle();
        check(ctrl_reset_n, 1'b1, "released");
        end_test("reset release");
        run_decode();
        // Interrupt level passes through the powered buffer
        @(posedge core_clk) ctrl_interrupt_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check(option_interrupt_request_n, 1'b0, "irq low");
        @(posedge core_clk) ctrl_interrupt_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        check(option_interrupt_request_n, 1'b1, "irq high");
        end_test("interrupt");
        // Back to battery: reset, isolation and decode all cut off
        @(posedge core_clk) ac_line_on_n <= 1'b1;
        obd_cpu_model_i.set_power();
        check(ctrl_reset_n, 1'b0, "reset on power off");
        check({ctrl_iso_oe, option_interrupt_request_oe}, 2'b00, "buffer off");
        obd_cpu_model_i.start_cycle(16'h002C, 1'b0, 8'h99);
        check({ctrl_chip_select_n, ctrl_data_oe}, 2'b10, "no select");
        obd_cpu_model_i.end_cycle();
        end_test("power off");
        complete_run();
    end

    // Watchdog well beyond the few hundred cycles the tests take
    initial begin
        repeat (4000) @(posedge core_clk);
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end

endmodule : tb_obd_top
